// File: include/ahc_pkg.sv
// package: constants and types of the converter host-control block
// assumes: one 200 MHz clock, all users import ahc_pkg::*
package ahc_pkg;
  // ==========================================
  // special register fields
  localparam int          SPREG_W         = 8;
  localparam int          PWR_DOWN_BIT    = 0;
  localparam int          SAMPLE_HOLD_BIT = 2;
  localparam int          RSV_FOUR_BIT    = 4;
  localparam int          RSV_SIX_BIT     = 6;
  localparam logic [7:0]  SPREG_RESET     = 8'h00;
  // ==========================================
  // result and timing
  localparam int          RES_W           = 12;
  localparam int          SAMPLE_CYCLES   = 5;
  localparam int          CONV_CYCLES_DEF = 17;
  localparam int          CAL_CYCLES_DEF  = 100;
  localparam int          CNT_W           = 16;
  localparam logic [11:0] RESULT_RESET    = 12'h000;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  // ==========================================
  // engine states, one-hot
  typedef enum logic [2:0] {
    AHC_IDLE = 3'b001,
    AHC_CONV = 3'b010,
    AHC_CAL  = 3'b100
  } ahc_state_e;
endpackage

// File: include/ahc_pins_if.sv
// interface: synchronised host control pins, sync stage to core
// assumes: both ends on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
interface ahc_pins_if;
  logic       cs_b;
  logic       rd_b;
  logic       wr_b;
  logic       special_register_select;
  logic       upper_byte_select;
  logic       cal;
  logic [7:0] data;
  modport syn  (output cs_b, rd_b, wr_b, special_register_select, upper_byte_select, cal, data);
  modport core (input  cs_b, rd_b, wr_b, special_register_select, upper_byte_select, cal, data);
endinterface
`default_nettype wire

// File: core/ahc_sync.sv
// two-flop synchroniser for all host pins
// assumes: pins are asynchronous to sys_clk_i; only stage two is exported
`timescale 1ns/1ps
`default_nettype none
module ahc_sync
  import ahc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // raw pins
  input  wire logic [5:0] ctl_i,
  input  wire logic [7:0] data_i,
  // synchronised side
  ahc_pins_if.syn         pins
);
  typedef struct packed {
    logic [13:0] s1;
    logic [13:0] s2;
  } ahc_sync_s;

  ahc_sync_s st;
  ahc_sync_s next_st;

  // ==========================================
  // stage one feeds stage two only
  always_comb begin
    next_st    = st;
    next_st.s1 = {ctl_i, data_i};
    next_st.s2 = st.s1;
  end

  // idle level of strobes is high, so reset to ones avoids false edges
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st <= '{s1: 14'h3FFF, s2: 14'h3FFF};
    end else begin
      st <= next_st;
    end
  end

  assign pins.cs_b                    = st.s2[13];
  assign pins.rd_b                    = st.s2[12];
  assign pins.wr_b                    = st.s2[11];
  assign pins.special_register_select = st.s2[10];
  assign pins.upper_byte_select       = st.s2[9];
  assign pins.cal                     = st.s2[8];
  assign pins.data                    = st.s2[7:0];
endmodule
`default_nettype wire

// File: core/ahc_top.sv
// top: host control decode, special register, conversion and calibration sequencing
// assumes: host pins asynchronous; adc_code_i comes from the analog core on sys_clk_i
`timescale 1ns/1ps
`default_nettype none
// Function
// - rising calibration input starts calibration, unless sample/hold mode reassigns it
// - busy low during conversion or calibration; conversion starts ignored meanwhile, a calibration rise restarts calibration
// - chip select high and calibration high: no action, bus undriven
// - write rising edge with valid selects and not busy starts a conversion
// - write with both selects high loads the special register
// - read with both selects low drives the result low byte
// - read with upper byte select and special register select low drives the result high byte
// - read with both selects high drives the special register
// - sample/hold bit makes the calibration input the conversion start
// - in power-down one write triggers one conversion, then back to power-down
// - analog input sampled during the first five cycles of conversion
module ahc_top
  import ahc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter int CAL_CYCLES  = CAL_CYCLES_DEF
)(
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  // host control pins
  input  wire logic             cs_b_i,
  input  wire logic             rd_b_i,
  input  wire logic             wr_b_i,
  input  wire logic             special_register_select_i,
  input  wire logic             upper_byte_select_i,
  input  wire logic             cal_i,
  // host data bus, three signals
  input  wire logic [7:0]       data_i,
  output logic      [7:0]       data_o,
  output logic                  data_oe_b_o,
  // status
  output logic                  busy_b_o,
  // analog core side
  input  wire logic [RES_W-1:0] adc_code_i,
  output logic                  sample_o,
  output logic                  powered_o
);
  // elaboration check: the counter cannot serve longer runs
  if (CONV_CYCLES <= SAMPLE_CYCLES || CONV_CYCLES >= (1 << CNT_W) || CAL_CYCLES < 1 ||
      CAL_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("ahc_top: cycle counts out of range");
  end

  localparam logic [CNT_W-1:0] CONV_LAST   = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_LAST    = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);

  // ==========================================
  // synchronised pins
  ahc_pins_if pins ();
  logic cal_raw;

  ahc_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ctl_i     ({cs_b_i, rd_b_i, wr_b_i, special_register_select_i, upper_byte_select_i, cal_i}),
    .data_i    (data_i),
    .pins      (pins.syn)
  );

  // every pin crosses in the sync module; edge memories reset to the idle level of their pin
  typedef struct packed {
    ahc_state_e         state;
    logic [CNT_W-1:0]   cnt;
    logic [RES_W-1:0]   result;
    logic [SPREG_W-1:0] spreg;
    logic [7:0]         dout;
    logic               doe_b;
    logic               busy_b;
    logic               sample;
    logic               powered;
    logic               wr_q;
    logic               cal_q;
  } ahc_top_s;

  ahc_top_s st;
  ahc_top_s next_st;

  // read decode drives the enable only; the bus mux decodes the selects alone
  function automatic logic read_hit(input logic cs_b, input logic rd_b, input logic wr_b,
                                    input logic cal_ok);
    return !cs_b && !rd_b && wr_b && cal_ok;
  endfunction

  logic sh_mode;
  logic cal_ok;
  logic wr_rise;
  logic cal_rise;
  logic conv_req;
  logic rd_now;

  assign cal_raw  = pins.cal;
  assign sh_mode  = st.spreg[SAMPLE_HOLD_BIT];
  assign cal_ok   = cal_raw || sh_mode;
  assign wr_rise  = !st.wr_q && pins.wr_b;
  assign cal_rise = !st.cal_q && cal_raw;
  assign rd_now   = read_hit(pins.cs_b, pins.rd_b, pins.wr_b, cal_ok);
  // write start needs select low, or both selects high
  assign conv_req = sh_mode ? cal_rise :
                    (wr_rise && !pins.cs_b && pins.rd_b && cal_raw &&
                     (!pins.special_register_select || pins.upper_byte_select));

  // ==========================================
  // next state
  always_comb begin
    next_st        = st;
    next_st.cal_q  = cal_raw;
    next_st.wr_q   = pins.wr_b;
    // register loads on the closing write edge, data is stable there
    if (wr_rise && !pins.cs_b && pins.rd_b && cal_ok && pins.special_register_select &&
        pins.upper_byte_select) begin
      next_st.spreg = pins.data;
    end
    // sequencing
    case (st.state)
      AHC_IDLE: begin
        if (cal_rise && !sh_mode) begin
          next_st.state  = AHC_CAL;
          next_st.cnt    = '0;
          next_st.busy_b = 1'b0;
        end else if (conv_req) begin
          next_st.state   = AHC_CONV;
          next_st.cnt     = '0;
          next_st.busy_b  = 1'b0;
          next_st.sample  = 1'b1;
          next_st.powered = 1'b1;
        end
      end
      // conversion starts are decoded in idle only, so they are dropped while busy; a calibration rise still aborts or restarts
      AHC_CONV: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt == SAMPLE_LAST) begin
          next_st.sample = 1'b0;
        end
        if (cal_rise && !sh_mode) begin
          next_st.state  = AHC_CAL;
          next_st.cnt    = '0;
          next_st.sample = 1'b0;
        end else if (st.cnt == CONV_LAST) begin
          next_st.state   = AHC_IDLE;
          next_st.result  = adc_code_i;
          next_st.busy_b  = 1'b1;
          next_st.powered = !st.spreg[PWR_DOWN_BIT];
        end
      end
      AHC_CAL: begin
        next_st.cnt = st.cnt + 1'b1;
        if (cal_rise && !sh_mode) begin
          next_st.cnt = '0;
        end else if (st.cnt == CAL_LAST) begin
          next_st.state   = AHC_IDLE;
          next_st.busy_b  = 1'b1;
          next_st.powered = !st.spreg[PWR_DOWN_BIT];
        end
      end
      default: begin
        next_st.state  = AHC_IDLE;
        next_st.busy_b = 1'b1;
        next_st.sample = 1'b0;
      end
    endcase
    // power-down reached with no conversion in flight
    if (st.state == AHC_IDLE && next_st.state == AHC_IDLE) begin
      next_st.powered = !next_st.spreg[PWR_DOWN_BIT];
    end
    // ==========================================
    // bus output; reserved read gives zeros
    next_st.doe_b = !rd_now;
    if (!pins.special_register_select) begin
      next_st.dout = pins.upper_byte_select ? {4'h0, st.result[11:8]}
                                            : st.result[7:0];
    end else if (pins.upper_byte_select) begin
      next_st.dout = st.spreg;
    end else begin
      next_st.dout = DATA_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st <= '{state: AHC_IDLE, cnt: '0, result: RESULT_RESET, spreg: SPREG_RESET, dout: DATA_RESET,
              doe_b: 1'b1, busy_b: 1'b1, sample: 1'b0, powered: 1'b1, wr_q: 1'b1,
              cal_q: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign data_o      = st.dout;
  assign data_oe_b_o = st.doe_b;
  assign busy_b_o    = st.busy_b;
  assign sample_o    = st.sample;
  assign powered_o   = st.powered;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  busy_tracks_state_a: assert property ((st.state != AHC_IDLE) |-> !busy_b_o)
    else $error("busy high while working");
  no_restart_a: assert property (st.state == AHC_CONV && !(cal_rise && !sh_mode) && st.cnt != CONV_LAST
                                 |=> st.cnt == $past(st.cnt) + 1'b1)
    else $error("conversion restarted");
  cal_start_a: assert property (st.state == AHC_IDLE && cal_rise && !sh_mode |=> st.state == AHC_CAL)
    else $error("calibration not started");
  idle_hiz_a: assert property (pins.cs_b |=> data_oe_b_o)
    else $error("bus driven while deselected");
  conv_start_a: assert property (st.state == AHC_IDLE && conv_req && !cal_rise
                                 |=> st.state == AHC_CONV && !busy_b_o && sample_o)
    else $error("conversion not started");
  spreg_load_a: assert property (wr_rise && !pins.cs_b && pins.rd_b && cal_ok && pins.special_register_select
                                 && pins.upper_byte_select |=> st.spreg == $past(pins.data))
    else $error("register not loaded");
  low_byte_a: assert property (rd_now && !pins.special_register_select && !pins.upper_byte_select
                               |=> !data_oe_b_o && data_o == $past(st.result[7:0]))
    else $error("low byte wrong");
  high_byte_a: assert property (rd_now && !pins.special_register_select && pins.upper_byte_select
                                |=> data_o == {4'h0, $past(st.result[11:8])})
    else $error("high byte wrong");
  spreg_read_a: assert property (rd_now && pins.special_register_select && pins.upper_byte_select
                                 |=> data_o == $past(st.spreg))
    else $error("register readback wrong");
  sh_start_a: assert property (st.state == AHC_IDLE && sh_mode && cal_rise |=> st.state == AHC_CONV)
    else $error("sample/hold start missed");
  sample_len_a: assert property ($rose(sample_o) |-> sample_o [*5] ##1 !sample_o)
    else $error("sample window not five cycles");
  pd_return_a: assert property (st.state == AHC_CONV && st.cnt == CONV_LAST && !(cal_rise && !sh_mode)
                                && st.spreg[PWR_DOWN_BIT] |=> !powered_o && busy_b_o)
    else $error("power-down not resumed");

  conv_done_c: cover property (st.state == AHC_CONV ##1 st.state == AHC_IDLE);
  cal_done_c: cover property (st.state == AHC_CAL ##1 st.state == AHC_IDLE);
  spreg_read_c: cover property (rd_now && pins.special_register_select && pins.upper_byte_select);
  pd_conv_c: cover property (st.spreg[PWR_DOWN_BIT] && st.state == AHC_CONV);
endmodule
`default_nettype wire

// File: core/ahc_sync_fix_note.sv
// holds no logic: the pin synchroniser lives in ahc_sync.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: tb/ahc_host_model.sv
// host processor model: drives the control pins and data bus of the block
// assumes: shares the block clock; pins change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
module ahc_host_model (
  // clock
  input  wire logic       clk_i,
  // control pins
  output logic            cs_b_o,
  output logic            rd_b_o,
  output logic            wr_b_o,
  output logic            special_register_select_o,
  output logic            upper_byte_select_o,
  output logic            cal_o,
  output logic [7:0]      data_o,
  // bus as driven by the block
  input  wire logic [7:0] bus_i,
  input  wire logic       bus_oe_b_i
);
  // ==========================================
  // idle: strobes high; data inverted once released so a stale value never looks valid
  initial begin
    cs_b_o = 1'b1;
    rd_b_o = 1'b1;
    wr_b_o = 1'b1;
    special_register_select_o = 1'b0;
    upper_byte_select_o = 1'b0;
    cal_o = 1'b1;
    data_o = 8'h00;
  end
  // ==========================================
  // each level held at least four edges except the chip-select release that ends wr_cycle, the sync stage needs two
  task automatic wr_cycle(input logic s, input logic u, input logic [7:0] d);
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    wr_b_o <= 1'b0;
    special_register_select_o <= s;
    upper_byte_select_o <= u | s;
    data_o <= d & 8'hAF;
    repeat (4) @(posedge clk_i);
    wr_b_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cs_b_o <= 1'b1;
    data_o <= ~(d & 8'hAF);
  endtask
  task automatic rd_cycle(input logic s, input logic u, input logic cs, output logic [7:0] q,
                          output logic oe_b);
    @(posedge clk_i);
    cs_b_o <= cs;
    rd_b_o <= 1'b0;
    special_register_select_o <= s;
    upper_byte_select_o <= u | s;
    repeat (6) @(posedge clk_i);
    q = bus_i;
    oe_b = bus_oe_b_i;
    cs_b_o <= 1'b1;
    rd_b_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // also the extra calibration a host issues once a late reference settles
  task automatic cal_pulse();
    @(posedge clk_i);
    cal_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cal_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/test_adc_host_control_decode.sv
// testbench: host model against the control decode top, counts busy and sample cycles
// assumes: conversion and short calibration counts set by parameter
`timescale 1ns/1ps
`default_nettype none
module test_adc_host_control_decode;
  import ahc_pkg::*;
  localparam int CONV_N = 20;
  localparam int CAL_N  = 12;
  localparam int LIMIT  = 6000;
  // ==========================================
  // signals
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic        cs_b, rd_b, wr_b, special_register_select, upper_byte_select, cal;
  logic [7:0]  host_data, bus_q, q;
  logic        bus_oe_b, busy_b, sample, powered, oe, busy_q;
  int          busy_lo, samp_hi, falls, cycles, error_cnt, checks, b0, s0, f0;
  initial begin
    busy_lo = 0;
    samp_hi = 0;
    falls = 0;
    cycles = 0;
    error_cnt = 0;
    checks = 0;
    busy_q = 1'b1;
  end
  always #2.5 sys_clk = ~sys_clk;
  ahc_host_model host (.clk_i(sys_clk), .cs_b_o(cs_b), .rd_b_o(rd_b), .wr_b_o(wr_b),
    .special_register_select_o(special_register_select), .upper_byte_select_o(upper_byte_select),
    .cal_o(cal), .data_o(host_data), .bus_i(bus_q), .bus_oe_b_i(bus_oe_b));
  ahc_top #(.CONV_CYCLES(CONV_N), .CAL_CYCLES(CAL_N)) dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .cs_b_i(cs_b), .rd_b_i(rd_b), .wr_b_i(wr_b), .special_register_select_i(special_register_select),
    .upper_byte_select_i(upper_byte_select), .cal_i(cal), .data_i(host_data), .data_o(bus_q),
    .data_oe_b_o(bus_oe_b), .busy_b_o(busy_b), .adc_code_i(adc_code), .sample_o(sample),
    .powered_o(powered));
  // ==========================================
  // cycle counters; a hang is cut at LIMIT
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    busy_q <= busy_b;
    if (busy_b === 1'b0) busy_lo <= busy_lo + 1;
    if (sample === 1'b1) samp_hi <= samp_hi + 1;
    if (busy_q === 1'b1 && busy_b === 1'b0) falls <= falls + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // snapshot while idle, counters are still then
  task automatic snap();
    b0 = busy_lo;
    s0 = samp_hi;
    f0 = falls;
  endtask
  task automatic check_run(input int n);
    repeat (60) @(posedge sys_clk);
    check(16'(busy_lo - b0), 16'(n));
    check(16'(falls - f0), 16'h0001);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    check({15'h0000, bus_oe_b}, 16'h0001);
    check({15'h0000, busy_b}, 16'h0001);
    check({15'h0000, powered}, 16'h0001);
  endtask
  task automatic t_register();
    snap();
    host.wr_cycle(1'b1, 1'b1, 8'h88);
    check_run(CONV_N);
    check(16'(samp_hi - s0), 16'(SAMPLE_CYCLES));
    host.rd_cycle(1'b1, 1'b1, 1'b0, q, oe);
    check({8'h00, q}, 16'h0088);
    check({15'h0000, oe}, 16'h0000);
  endtask
  task automatic t_result();
    adc_code <= 12'hA5C;
    snap();
    host.wr_cycle(1'b0, 1'b0, 8'h00);
    check_run(CONV_N);
    adc_code <= 12'h3C1;
    host.rd_cycle(1'b0, 1'b0, 1'b0, q, oe);
    check({7'h00, oe, q}, 16'h005C);
    host.rd_cycle(1'b0, 1'b1, 1'b0, q, oe);
    check({7'h00, oe, q}, 16'h000A);
    host.rd_cycle(1'b0, 1'b0, 1'b1, q, oe);
    check({15'h0000, oe}, 16'h0001);
  endtask
  // second start lands mid-conversion and must not stretch it
  task automatic t_busy_ignore();
    snap();
    host.wr_cycle(1'b0, 1'b1, 8'h00);
    host.wr_cycle(1'b0, 1'b0, 8'h00);
    check_run(CONV_N);
  endtask
  task automatic t_cal();
    snap();
    host.cal_pulse();
    check_run(CAL_N);
  endtask
  task automatic t_power_down();
    host.wr_cycle(1'b1, 1'b1, 8'h01);
    repeat (60) @(posedge sys_clk);
    check({15'h0000, powered}, 16'h0000);
    snap();
    host.wr_cycle(1'b0, 1'b0, 8'h00);
    check_run(CONV_N);
    check({15'h0000, powered}, 16'h0000);
    host.wr_cycle(1'b1, 1'b1, 8'h00);
    repeat (60) @(posedge sys_clk);
    check({15'h0000, powered}, 16'h0001);
  endtask
  task automatic t_sample_hold();
    host.wr_cycle(1'b1, 1'b1, 8'h04);
    repeat (60) @(posedge sys_clk);
    snap();
    host.cal_pulse();
    check_run(CONV_N);
    check(16'(samp_hi - s0), 16'(SAMPLE_CYCLES));
    host.rd_cycle(1'b1, 1'b1, 1'b0, q, oe);
    check({7'h00, oe, q}, 16'h0004);
    host.wr_cycle(1'b1, 1'b1, 8'h00);
    repeat (60) @(posedge sys_clk);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_register();
    t_result();
    t_busy_ignore();
    t_cal();
    t_power_down();
    t_sample_hold();
    wrap_up();
  end
endmodule
`default_nettype wire
